// ==== hw/ao_param_pkg.sv ====
package ao_param_pkg;
  // ---------------------------------------------------------------
  // channel count and word layout
  // ---------------------------------------------------------------
  localparam int unsigned NUM_CH     = 4;
  localparam int unsigned WORD_W     = 16;
  localparam int unsigned SIGN_BIT   = 15;
  localparam int unsigned RES_12     = 12;
  // ---------------------------------------------------------------
  // parameter area byte offsets, set 0 and set 1
  // ---------------------------------------------------------------
  localparam logic [3:0] OFS_GROUP_DIAG   = 4'h0;
  localparam logic [3:0] OFS_RS0_RESERVED = 4'h1;
  localparam logic [3:0] OFS_IRQ_RELEASE  = 4'h0;
  localparam logic [3:0] OFS_STOP_REACT   = 4'h1;
  localparam logic [3:0] OFS_MODE_CH0     = 4'h2;
  localparam logic [3:0] OFS_SUBST_CH0    = 4'h6;
  localparam logic [3:0] RS1_LAST_BYTE    = 4'hD;
  localparam int unsigned IRQ_RELEASE_BIT = 6;
  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0]  RST_BYTE   = 8'h00;
  localparam logic [7:0]  RST_MODE   = 8'h19;
  localparam logic [15:0] RST_SUBST  = 16'h0000;
  localparam logic [7:0]  MODE_OFF   = 8'h00;
  localparam logic [3:0]  DIAG_MASK  = 4'hF;
  // ---------------------------------------------------------------
  // mode nibble codes
  // ---------------------------------------------------------------
  localparam logic [3:0] TYPE_VOLT   = 4'h1;
  localparam logic [3:0] TYPE_CURR   = 4'h2;
  localparam logic [3:0] RNG_0_10V   = 4'h8;
  localparam logic [3:0] RNG_1_5V    = 4'h7;
  localparam logic [3:0] RNG_PM10V   = 4'h9;
  localparam logic [3:0] RNG_0_20MA  = 4'h2;
  localparam logic [3:0] RNG_4_20MA  = 4'h3;
  localparam logic [3:0] RNG_PM20MA  = 4'h4;
  // ---------------------------------------------------------------
  // scaling points and settling time
  // ---------------------------------------------------------------
  localparam logic signed [15:0] NOMINAL_END   = 16'sh6C00; // 27648
  localparam logic signed [15:0] OVER_END      = 16'sh7EFF; // 32511
  localparam logic signed [15:0] UNDER_ASYM    = 16'shE500; // -6912
  localparam logic signed [15:0] UNDER_SYM     = 16'sh8100; // -32512
  localparam int unsigned SETTLE_MS         = 10;
  localparam int unsigned CLK_MHZ           = 200;
  localparam int unsigned SETTLE_CYCLES     = SETTLE_MS * 1000 * CLK_MHZ;
endpackage

// ==== hw/ao_param_ctrl.sv ====
`timescale 1ns/1ps
// Notes on behaviour
// R1 - outputs may be wrong about 10ms after power or range change; settle flag
// R2 - output word is 16 bits, high byte first then low byte
// R3 - bit 15 of each output word is the sign, one means negative
// R4 - bits below the variant resolution are ignored
// R5 - unsupported parameter values are flagged wrong and raise an error
// R6 - parameter area is 16 bytes: set zero 2 bytes, set one 14 bytes
// R7 - controller never rewrites set zero at run time; this module takes set zero writes only while cpu_run is high
// R8 - set zero byte 0 bits 3..0 enable channel group diagnosis, rest reserved
// R9 - set one byte 0 bit 6 releases the diagnostic interrupt
// R10 - set one byte 1 bits 3..0 pick each channel's stop reaction
// R11 - set one bytes 2..5 hold channel modes, type high nibble, range low
// R12 - mode byte 00h deactivates that channel
// R13 - set one bytes 6..13 hold substitute values, default 0000h
// R14 - controller uses E500h for zero output in asymmetric ranges
// R15 - parameters sent at CPU RUN are taken and applied then
// R16 - set one may be rewritten during operation and is applied
// R17 - type 0001b voltage: ranges 1000b, 0111b, 1001b
// R18 - type 0010b current: ranges 0010b, 0011b, 0100b
// R19 - 27648 nominal end, 32511 overdrive end, -6912 asymmetric underdrive end
// R20 - stop bit clear gives substitute value, set holds last value
// R21 - reserved bits ignored on write, read as zero
module ao_param_ctrl #(
  parameter int unsigned RES_BITS      = ao_param_pkg::RES_12,
  parameter bit          ALLOW_VOLT    = 1'b1,
  parameter bit          ALLOW_CURR    = 1'b1,
  parameter logic [7:0]  MODE_DEFAULT  = ao_param_pkg::RST_MODE,
  parameter int unsigned SETTLE_CYCLES = ao_param_pkg::SETTLE_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        cpu_run,       // controller in RUN, same clock
  input  wire logic        out_wr,        // output byte strobe
  input  wire logic [2:0]  out_addr,      // channel*2 + byte (0 high, 1 low)
  input  wire logic [7:0]  out_data,
  input  wire logic        prm_wr,        // parameter byte strobe
  input  wire logic        prm_set,       // record set select
  input  wire logic [3:0]  prm_addr,
  input  wire logic [7:0]  prm_data,
  input  wire logic        prm_rd,
  output logic      [7:0]  prm_rdata,
  output logic      [63:0] dac_word,      // four 16-bit words, ch0 in low bits
  output logic      [3:0]  ch_active,
  output logic      [3:0]  ch_is_current,
  output logic      [3:0]  ch_asym,
  output logic             wrong_param,
  output logic      [3:0]  group_diag_en,
  output logic             diag_irq_en,
  output logic             settling
);
  localparam int unsigned N = ao_param_pkg::NUM_CH;
  localparam logic [15:0] LSB_MASK = 16'hFFFF << (ao_param_pkg::SIGN_BIT - RES_BITS);

  // ---------------------------------------------------------------
  // parameter storage
  // ---------------------------------------------------------------
  logic [7:0]  group_diag_enable;
  logic [7:0]  diag_irq_release;
  logic [7:0]  stop_reaction_select;
  logic [7:0]  mode_ch   [N];
  logic [15:0] subst_ch  [N];
  logic [15:0] out_word  [N];
  logic [7:0]  out_hi    [N];
  logic [N-1:0] range_chg;
  logic        wrong_hit;
  logic [31:0] settle_cnt;

  // legality of one mode byte against the variant
  function automatic logic mode_ok(input logic [7:0] m);
    logic ok;
    ok = 1'b0;
    if (m == ao_param_pkg::MODE_OFF) ok = 1'b1; // R12
    else if (m[7:4] == ao_param_pkg::TYPE_VOLT) // R17
      ok = ALLOW_VOLT && (m[3:0] == ao_param_pkg::RNG_0_10V ||
           m[3:0] == ao_param_pkg::RNG_1_5V || m[3:0] == ao_param_pkg::RNG_PM10V);
    else if (m[7:4] == ao_param_pkg::TYPE_CURR) // R18
      ok = ALLOW_CURR && (m[3:0] == ao_param_pkg::RNG_0_20MA ||
           m[3:0] == ao_param_pkg::RNG_4_20MA || m[3:0] == ao_param_pkg::RNG_PM20MA);
    return ok;
  endfunction

  // set zero: written only while cpu_run is high, reserved bits dropped
  always_ff @(posedge clk)
  begin
    if (rst)
      group_diag_enable <= ao_param_pkg::RST_BYTE;
    else if (prm_wr && !prm_set && cpu_run && prm_addr == ao_param_pkg::OFS_GROUP_DIAG)
      group_diag_enable <= {4'h0, prm_data[3:0]}; // R8 R21 R6 R7
  end

  // set one flag bytes
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      diag_irq_release     <= ao_param_pkg::RST_BYTE;
      stop_reaction_select <= ao_param_pkg::RST_BYTE;
    end
    else if (prm_wr && prm_set)
    begin
      if (prm_addr == ao_param_pkg::OFS_IRQ_RELEASE)
        diag_irq_release <= {1'b0, prm_data[ao_param_pkg::IRQ_RELEASE_BIT], 6'h00}; // R9 R21
      if (prm_addr == ao_param_pkg::OFS_STOP_REACT)
        stop_reaction_select <= {4'h0, prm_data[3:0]}; // R10 R21 R16
    end
  end

  // wrong parameter flag: sticky until reset, so a refused byte is never missed
  always_ff @(posedge clk)
  begin
    if (rst)
      wrong_param <= 1'b0;
    else if (wrong_hit)
      wrong_param <= 1'b1; // R5
  end

  always_comb
  begin
    wrong_hit = 1'b0;
    if (prm_wr && prm_set && prm_addr >= ao_param_pkg::OFS_MODE_CH0 &&
        prm_addr < ao_param_pkg::OFS_SUBST_CH0 && !mode_ok(prm_data))
      wrong_hit = 1'b1; // R5
  end

  // ---------------------------------------------------------------
  // per-channel mode, substitute and output words
  // ---------------------------------------------------------------
  genvar c;
  generate
    for (c = 0; c < N; c++)
    begin : g_ch
      localparam logic [3:0] MADR = ao_param_pkg::OFS_MODE_CH0 + 4'(c);
      localparam logic [3:0] SADR = ao_param_pkg::OFS_SUBST_CH0 + 4'(2 * c);
      localparam logic [2:0] OADR = 3'(2 * c);

      // mode byte; unsupported values are refused and the old mode kept
      always_ff @(posedge clk)
      begin
        if (rst)
          mode_ch[c] <= MODE_DEFAULT;
        else if (prm_wr && prm_set && prm_addr == MADR && mode_ok(prm_data))
          mode_ch[c] <= prm_data; // R11 R15 R16
      end

      // range change marker for the settle timer
      assign range_chg[c] = prm_wr && prm_set && prm_addr == MADR &&
                            mode_ok(prm_data) && prm_data != mode_ch[c];

      // substitute value, high byte first
      always_ff @(posedge clk)
      begin
        if (rst)
          subst_ch[c] <= ao_param_pkg::RST_SUBST;
        else if (prm_wr && prm_set && prm_addr == SADR)
          subst_ch[c][15:8] <= prm_data; // R13
        else if (prm_wr && prm_set && prm_addr == SADR + 4'h1)
          subst_ch[c][7:0] <= prm_data; // R13
      end

      // output word: high byte held until low byte commits the word
      always_ff @(posedge clk)
      begin
        if (rst)
        begin
          out_hi[c]   <= ao_param_pkg::RST_BYTE;
          out_word[c] <= ao_param_pkg::RST_SUBST;
        end
        else if (out_wr && out_addr == OADR)
          out_hi[c] <= out_data; // R2
        else if (out_wr && out_addr == OADR + 3'h1)
          out_word[c] <= {out_hi[c], out_data}; // R2
      end

      // value driven to converter; stop reaction applies outside RUN
      always_ff @(posedge clk)
      begin
        if (rst)
          dac_word[16*c +: 16] <= ao_param_pkg::RST_SUBST;
        else if (mode_ch[c] == ao_param_pkg::MODE_OFF)
          dac_word[16*c +: 16] <= ao_param_pkg::RST_SUBST; // R12
        else if (cpu_run)
          dac_word[16*c +: 16] <= out_word[c] & LSB_MASK; // R3 R4 R19
        else if (!stop_reaction_select[c])
          dac_word[16*c +: 16] <= subst_ch[c] & LSB_MASK; // R20 R14
      end

      // channel status derived from mode
      always_ff @(posedge clk)
      begin
        if (rst)
        begin
          ch_active[c]     <= 1'b0;
          ch_is_current[c] <= 1'b0;
          ch_asym[c]       <= 1'b0;
        end
        else
        begin
          ch_active[c]     <= mode_ch[c] != ao_param_pkg::MODE_OFF; // R12
          ch_is_current[c] <= mode_ch[c][7:4] == ao_param_pkg::TYPE_CURR; // R18
          ch_asym[c]       <= mode_ch[c][3:0] == ao_param_pkg::RNG_1_5V ||
                              mode_ch[c][3:0] == ao_param_pkg::RNG_4_20MA; // R19
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // readback, diag outputs
  // ---------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst)
      prm_rdata <= ao_param_pkg::RST_BYTE;
    else if (prm_rd)
    begin
      prm_rdata <= ao_param_pkg::RST_BYTE; // R21
      if (!prm_set)
      begin
        if (prm_addr == ao_param_pkg::OFS_GROUP_DIAG)
          prm_rdata <= group_diag_enable;
      end
      else if (prm_addr == ao_param_pkg::OFS_IRQ_RELEASE)
        prm_rdata <= diag_irq_release;
      else if (prm_addr == ao_param_pkg::OFS_STOP_REACT)
        prm_rdata <= stop_reaction_select;
      else if (prm_addr < ao_param_pkg::OFS_SUBST_CH0)
        prm_rdata <= mode_ch[2'(prm_addr - ao_param_pkg::OFS_MODE_CH0)];
      else if (prm_addr <= ao_param_pkg::RS1_LAST_BYTE)
        prm_rdata <= prm_addr[0] ? subst_ch[2'((prm_addr - 4'h6) >> 1)][7:0]
                                 : subst_ch[2'((prm_addr - 4'h6) >> 1)][15:8];
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      group_diag_en <= 4'h0;
      diag_irq_en   <= 1'b0;
    end
    else
    begin
      group_diag_en <= group_diag_enable[3:0] & ao_param_pkg::DIAG_MASK; // R8
      diag_irq_en   <= diag_irq_release[ao_param_pkg::IRQ_RELEASE_BIT]; // R9
    end
  end

  // ---------------------------------------------------------------
  // settle window after reset or range change
  // ---------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      settle_cnt <= 32'h0;
      settling   <= 1'b1;
    end
    else if (|range_chg)
    begin
      settle_cnt <= 32'h0;
      settling   <= 1'b1; // R1
    end
    else if (settling)
    begin
      settle_cnt <= settle_cnt + 32'h1;
      if (settle_cnt == 32'(SETTLE_CYCLES - 1))
        settling <= 1'b0; // R1
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  // channel 3 is the one that gets switched off
  a_deact_zero: assert property (@(posedge clk) disable iff (rst) // R12
    mode_ch[3] == ao_param_pkg::MODE_OFF |=> dac_word[63:48] == 16'h0000)
    else $error("deactivated channel not zero");
  a_sign_kept: assert property (@(posedge clk) disable iff (rst) // R3
    cpu_run && mode_ch[0] != 8'h00 |=> dac_word[15] == $past(out_word[0][15]))
    else $error("sign bit not passed");
  a_lsb_clear: assert property (@(posedge clk) disable iff (rst) // R4
    (dac_word[15:0] & ~LSB_MASK) == 16'h0000)
    else $error("ignored bits not cleared");
  a_word_pair: assert property (@(posedge clk) disable iff (rst) // R2
    out_wr && out_addr == 3'h0 ##1 out_wr && out_addr == 3'h1 |=>
    out_word[0] == {$past(out_data, 2), $past(out_data)})
    else $error("word pairing wrong");
  a_wrong_flag: assert property (@(posedge clk) disable iff (rst) // R5
    wrong_hit |=> wrong_param)
    else $error("wrong parameter not flagged");
  a_stop_subst: assert property (@(posedge clk) disable iff (rst) // R20
    !cpu_run && !stop_reaction_select[0] && mode_ch[0] != 8'h00 |=>
    dac_word[15:0] == ($past(subst_ch[0]) & LSB_MASK))
    else $error("stop substitute not applied");
  // channel 1 is the one that holds its value at stop
  a_stop_hold: assert property (@(posedge clk) disable iff (rst) // R20
    !cpu_run && stop_reaction_select[1] && mode_ch[1] != 8'h00 |=>
    $stable(dac_word[31:16]))
    else $error("stop hold broken");
  a_irq_bit: assert property (@(posedge clk) disable iff (rst) // R9
    prm_wr && prm_set && prm_addr == 4'h0 |=> ##1 diag_irq_en == $past(prm_data[6], 2))
    else $error("irq release not taken");
  a_rsvd_zero: assert property (@(posedge clk) disable iff (rst) // R21
    group_diag_enable[7:4] == 4'h0 && stop_reaction_select[7:4] == 4'h0)
    else $error("reserved bits set");
  a_settle_set: assert property (@(posedge clk) disable iff (rst) // R1
    |range_chg |=> settling)
    else $error("settle not restarted");
endmodule

// ==== dv/cpu_model.sv ====
`timescale 1ns/1ps
// ----------------------------------------------------------------
// controller side of the backplane: output words and parameter bytes
// ----------------------------------------------------------------
module cpu_model (
  input  wire logic       clk,
  input  wire logic [7:0] prm_rdata,
  output logic            cpu_run,
  output logic            out_wr,
  output logic      [2:0] out_addr,
  output logic      [7:0] out_data,
  output logic            prm_wr,
  output logic            prm_set,
  output logic      [3:0] prm_addr,
  output logic      [7:0] prm_data,
  output logic            prm_rd
);
  // idle bus at time zero
  initial
  begin
    {cpu_run, out_wr, prm_wr, prm_set, prm_rd} = 5'h00;
    out_addr = 3'h0;
    out_data = 8'hA5;
    prm_addr = 4'h0;
    prm_data = 8'h5A;
  end
  // run level, parameters go down on entry to run
  task automatic set_run(input logic v);
    @(posedge clk);
    cpu_run <= v;
  endtask
  // one parameter byte to either set; set zero is taken only while cpu_run is high
  task automatic prm_write(input logic set, input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    prm_wr   <= 1'b1;
    prm_set  <= set;
    prm_addr <= a;
    prm_data <= d;
    @(posedge clk);
    prm_wr   <= 1'b0;
    prm_data <= ~d; // released bus never shows the old byte
  endtask
  // one output word: high byte then low byte, back to back
  task automatic out_write(input logic [1:0] ch, input logic [15:0] w);
    @(posedge clk);
    out_wr   <= 1'b1;
    out_addr <= {ch, 1'b0};
    out_data <= w[15:8];
    @(posedge clk);
    out_addr <= {ch, 1'b1};
    out_data <= w[7:0];
    @(posedge clk);
    out_wr   <= 1'b0;
    out_data <= ~w[7:0];
  endtask
  // one parameter read, data taken one cycle after the strobe
  task automatic prm_read(input logic set, input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    prm_rd   <= 1'b1;
    prm_set  <= set;
    prm_addr <= a;
    @(posedge clk);
    prm_rd   <= 1'b0;
    #1;
    d = prm_rdata;
  endtask
endmodule

// ==== dv/tb.sv ====
`timescale 1ns/1ps
module tb;
  // ----------------------------------------------------------------
  // clock, reset and wiring
  // ----------------------------------------------------------------
  localparam int unsigned SETTLE = 20;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        cpu_run, out_wr, prm_wr, prm_set, prm_rd, wrong_param, diag_irq_en, settling;
  logic [2:0]  out_addr;
  logic [3:0]  prm_addr, ch_active, ch_is_current, ch_asym, group_diag_en;
  logic [7:0]  out_data, prm_data, prm_rdata, rd, v;
  logic [63:0] dac_word;
  logic [15:0] w, last1, sub0, sub2;
  int          num_errors = 0;
  int          compares = 0;
  int          cycles = 0;
  logic [7:0]  modes [6] = '{8'h18, 8'h17, 8'h19, 8'h22, 8'h23, 8'h24};

  always #2.5 clk = ~clk;

  ao_param_ctrl #(.SETTLE_CYCLES(SETTLE)) dut (.clk(clk), .rst(rst), .cpu_run(cpu_run),
    .out_wr(out_wr), .out_addr(out_addr), .out_data(out_data), .prm_wr(prm_wr),
    .prm_set(prm_set), .prm_addr(prm_addr), .prm_data(prm_data), .prm_rd(prm_rd),
    .prm_rdata(prm_rdata), .dac_word(dac_word), .ch_active(ch_active),
    .ch_is_current(ch_is_current), .ch_asym(ch_asym), .wrong_param(wrong_param),
    .group_diag_en(group_diag_en), .diag_irq_en(diag_irq_en), .settling(settling));

  cpu_model cpu (.clk(clk), .prm_rdata(prm_rdata), .cpu_run(cpu_run), .out_wr(out_wr),
    .out_addr(out_addr), .out_data(out_data), .prm_wr(prm_wr), .prm_set(prm_set),
    .prm_addr(prm_addr), .prm_data(prm_data), .prm_rd(prm_rd));

  // ----------------------------------------------------------------
  // expectations and checking
  // ----------------------------------------------------------------
  function automatic logic [7:0] exp_reset(input logic set, input int a);
    if (set && a >= 2 && a <= 5)
      return ao_param_pkg::RST_MODE;
    return 8'h00;
  endfunction
  // bits below the resolution read as zero, sign kept
  function automatic logic [15:0] exp_dac(input logic [15:0] x);
    return x & (16'hFFFF << (ao_param_pkg::SIGN_BIT - ao_param_pkg::RES_12));
  endfunction
  function automatic logic [15:0] dac(input int c);
    return dac_word[16*c +: 16];
  endfunction
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("TB: %0d compares, %0d errors", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // hang guard, whole run is a few hundred cycles
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      num_errors++;
      stop_test();
    end
  end

  // ----------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------
  initial
  begin
    void'($urandom(32'h0980));
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    #1;
    check("settling", settling, 1'b1);
    for (int a = 0; a < 16; a++)
    begin
      cpu.prm_read(1'b1, a[3:0], rd);
      check("set1 reset", rd, exp_reset(1'b1, a));
      cpu.prm_read(1'b0, a[3:0], rd);
      check("set0 reset", rd, 8'h00);
    end
    $display("TB: test reset done");
    cpu.set_run(1'b1);
    for (int i = 0; i < 4; i++)
    begin
      v = (i == 0) ? 8'hFF : 8'($urandom);
      for (int a = 0; a < 4; a++)
        cpu.prm_write(a[1], {2'h0, 1'b0, a[0]}, v);
      repeat (2) @(posedge clk);
      #1;
      check("group diag", group_diag_en, v[3:0]);
      check("irq release", diag_irq_en, v[6]);
      cpu.prm_read(1'b0, 4'h0, rd);
      check("set0 byte0", rd, v & 8'h0F);
      cpu.prm_read(1'b0, 4'h1, rd);
      check("set0 byte1", rd, 8'h00);
      cpu.prm_read(1'b1, 4'h0, rd);
      check("set1 byte0", rd, v & 8'h40);
      cpu.prm_read(1'b1, 4'h1, rd);
      check("set1 byte1", rd, v & 8'h0F);
    end
    $display("TB: test flags done");
    for (int i = 0; i < 6; i++)
    begin
      cpu.prm_write(1'b1, 4'(2 + i % 4), modes[i]);
      repeat (2) @(posedge clk);
      #1;
      check("settle start", settling, 1'b1);
      check("current", ch_is_current[i % 4], modes[i][7:4] == 4'h2);
      check("asym", ch_asym[i % 4], modes[i] == 8'h17 || modes[i] == 8'h23);
      check("active", ch_active[i % 4], 1'b1);
      cpu.prm_read(1'b1, 4'(2 + i % 4), rd);
      check("mode read", rd, modes[i]);
    end
    check("no wrong", wrong_param, 1'b0);
    cpu.prm_write(1'b1, 4'h2, 8'h35);
    repeat (2) @(posedge clk);
    #1;
    check("wrong param", wrong_param, 1'b1);
    cpu.prm_read(1'b1, 4'h2, rd);
    check("mode kept", rd, 8'h23);
    cpu.prm_write(1'b1, 4'h5, ao_param_pkg::MODE_OFF);
    for (int c = 0; c < 3; c++)
      cpu.prm_write(1'b1, 4'(2 + c), 8'h19);
    repeat (SETTLE + 5) @(posedge clk);
    #1;
    check("settled", settling, 1'b0);
    check("off", ch_active, 4'h7);
    $display("TB: test modes done");
    for (int i = 0; i < 12; i++)
    begin
      w = (i < 3) ? ((i == 0) ? 16'h8000 : (i == 1) ? 16'h7EFF : 16'hE500) : 16'($urandom);
      cpu.out_write(2'(i % 3), w);
      repeat (4) @(posedge clk);
      #1;
      check("out word", dac(i % 3), exp_dac(w));
      check("off ch", dac(3), 16'h0000);
      if (i % 3 == 1)
        last1 = exp_dac(w);
    end
    $display("TB: test words done");
    sub0 = 16'hE500;
    sub2 = 16'($urandom) & 16'hFFF8;
    cpu.prm_write(1'b1, 4'h6, sub0[15:8]);
    cpu.prm_write(1'b1, 4'h7, sub0[7:0]);
    cpu.prm_write(1'b1, 4'hA, sub2[15:8]);
    cpu.prm_write(1'b1, 4'hB, sub2[7:0]);
    cpu.prm_write(1'b1, 4'h1, 8'h02);
    cpu.set_run(1'b0);
    cpu.prm_write(1'b0, 4'h0, ~v);
    repeat (4) @(posedge clk);
    #1;
    check("stop subst", dac(0), sub0);
    check("stop hold", dac(1), last1);
    check("stop subst2", dac(2), sub2);
    check("set0 refused", group_diag_en, v[3:0]);
    $display("TB: test stop done");
    stop_test();
  end
endmodule
